// ### hdl/lssc_top.sv
// Control logic of a six-channel low-side switch, serial and parallel
`timescale 1ns/1ps

module lssc_top
  import lssc_pkg::*;
(
  input wire logic CLK_SYS, // System clock, 100 MHz
  input wire logic RST_B, // Power-up reset, active low, synchronous
  input wire logic SCLK, // Serial clock from controller
  input wire logic CS_B, // Chip select, active low
  input wire logic SI, // Serial data in
  output logic SO_O, // Serial data out value
  output logic SO_OE, // Serial data out enable
  input wire logic EN_B, // Enable, active low
  input wire logic PAR_IN0, // Parallel input 0
  input wire logic PAR_IN1, // Parallel input 1
  input wire logic PAR_IN2_MODE_SELECT, // Parallel input 2, digital level
  input wire logic MODE_MID, // Mode select pin at intermediate level
  input wire logic OVERVOLTAGE, // Supply sense above threshold
  input wire logic [5:0] CUR_LIMIT, // Per channel current limit active
  input wire logic [5:0] OPEN_LOAD, // Per channel open-load indication
  output logic [5:0] OUT_CH, // Output switch drive per channel
  output logic DUAL_MODE, // Dual mode resolved
  output logic SLEEP_ACTIVE // Sleep state, serial port held cleared
);

  typedef struct packed {
    logic [18:0] in_meta;
    logic [18:0] in_sync;
    logic cs_prev;
    lssc_pwr_type pwr;
    logic [11:0] dead_cnt;
    logic dual;
    logic [11:0] mode_cnt;
    logic [7:0] cmd;
    logic [5:0] fault;
    logic [5:0] retry;
    logic [5:0][11:0] tmr;
    logic [5:0] out;
    logic [7:0] stat;
    logic ser_clr;
  } lssc_sys_type;

  localparam lssc_sys_type SYS_RST = '{
    in_meta: SYNC_RST,
    in_sync: SYNC_RST,
    cs_prev: 1'b1,
    pwr: PWR_DEAD,
    dead_cnt: POR_CYC,
    dual: 1'b0,
    mode_cnt: 12'h000,
    cmd: CMD_RST,
    fault: 6'h00,
    retry: 6'h00,
    tmr: '0,
    out: 6'h00,
    stat: STAT_RST,
    ser_clr: 1'b1
  };

  lssc_sys_type st_reg;
  lssc_sys_type st_next;
  logic [7:0] rx_reg;
  logic [3:0] tx_cnt_reg;
  logic so_hold_reg;

  // ------------------------------------------------------------
  // Link side, clocked by SCLK
  // ------------------------------------------------------------
  // Shift register is held clear from the system side while asleep
  always_ff @(posedge SCLK or posedge st_reg.ser_clr) begin
    if (st_reg.ser_clr) begin
      rx_reg <= 8'h00;
    end else if (!CS_B) begin
      rx_reg <= {rx_reg[6:0], SI};
    end
  end

  // Falling edges since select; the count stops at SO_LAST_CNT, after the last status bit
  always_ff @(negedge SCLK or posedge CS_B) begin
    if (CS_B) begin
      tx_cnt_reg <= 4'h0;
    end else if (tx_cnt_reg != SO_LAST_CNT) begin
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
    end
  end

  // Daisy-chained bits must also move on falling edges only, so the
  // controller sees them stable at its rising-edge capture
  always_ff @(negedge SCLK) begin
    so_hold_reg <= rx_reg[7];
  end

  // Status word is frozen while selected, so it is stable across domains
  always_comb begin
    if (tx_cnt_reg < SO_LAST_CNT) begin
      SO_O = st_reg.stat[3'h7 - tx_cnt_reg[2:0]];
    end else begin
      SO_O = so_hold_reg;
    end
  end

  // Driven only while selected and awake
  assign SO_OE = !CS_B && !st_reg.ser_clr;

  // ------------------------------------------------------------
  // System side
  // ------------------------------------------------------------
  logic cs_s;
  logic cs_rise;
  logic en_s;
  logic mid_s;
  logic ov_s;
  logic ser_ok;
  logic grp0;
  logic grp1;
  logic [5:0] dem;
  logic [5:0] fset;
  logic [5:0] cl_s;
  logic [5:0] ol_s;

  always_comb begin
    st_next = st_reg;
    cs_s = st_reg.in_sync[IX_CS];
    en_s = st_reg.in_sync[IX_EN];
    mid_s = st_reg.in_sync[IX_MID];
    ov_s = st_reg.in_sync[IX_OV];
    cl_s = st_reg.in_sync[IX_CL +: 6];
    ol_s = st_reg.in_sync[IX_OL +: 6];
    cs_rise = cs_s && !st_reg.cs_prev;
    fset = 6'h00;
    st_next.in_meta = {OVERVOLTAGE, MODE_MID, PAR_IN2_MODE_SELECT, PAR_IN1,
                       PAR_IN0, EN_B, CS_B, CUR_LIMIT, OPEN_LOAD};
    st_next.in_sync = st_reg.in_meta;
    st_next.cs_prev = cs_s;

    // Mode filter; a valid high or low level drops back to hex at once
    if (!mid_s) begin
      st_next.mode_cnt = 12'h000;
      st_next.dual = 1'b0;
    end else if (st_reg.mode_cnt != MODE_CYC) begin
      st_next.mode_cnt = st_reg.mode_cnt + 12'h001;
    end else begin
      st_next.dual = 1'b1;
    end

    // Command word; may pass 8 bits of any frame length
    if (cs_rise && st_reg.pwr != PWR_SLEEP) begin
      st_next.cmd = rx_reg;
    end

    case (st_reg.pwr)
      PWR_DEAD: begin
        if (en_s && st_reg.cmd[CMD_SLEEP_BIT]) begin
          st_next.pwr = PWR_SLEEP;
        end else if (st_reg.dead_cnt == 12'h000) begin
          st_next.pwr = PWR_RUN;
        end else begin
          st_next.dead_cnt = st_reg.dead_cnt - 12'h001;
        end
      end
      PWR_RUN: begin
        // Enable going low here keeps running: no dead time
        if (en_s && st_reg.cmd[CMD_SLEEP_BIT]) begin
          st_next.pwr = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        st_next.cmd = CMD_RST;
        if (!en_s) begin
          st_next.pwr = PWR_DEAD;
          st_next.dead_cnt = POR_CYC;
        end
      end
      default: begin
        st_next.pwr = PWR_DEAD;
      end
    endcase

    // Serial control only with enable low
    ser_ok = !en_s;
    grp0 = st_reg.in_sync[IX_PAR0] ||
           (ser_ok && st_reg.cmd[0] && st_reg.cmd[4] && st_reg.cmd[5]);
    grp1 = st_reg.in_sync[IX_PAR1] ||
           (ser_ok && st_reg.cmd[1] && st_reg.cmd[2] && st_reg.cmd[3]);
    if (st_reg.dual) begin
      dem = {grp0, grp0, grp1, grp1, grp1, grp0};
    end else begin
      dem[2:0] = st_reg.in_sync[IX_PAR0 +: 3] |
                 (st_reg.cmd[2:0] & {3{ser_ok}});
      dem[5:3] = st_reg.cmd[5:3] & {3{ser_ok}};
    end

    // Per channel fault timing; detection only while running
    for (int i = 0; i < NUM_CH; i++) begin
      if (st_reg.pwr != PWR_RUN) begin
        st_next.retry[i] = 1'b0;
        st_next.tmr[i] = 12'h000;
      end else if (st_reg.retry[i]) begin
        if (st_reg.tmr[i] == RETRY_CYC) begin
          st_next.retry[i] = 1'b0;
          st_next.tmr[i] = 12'h000;
        end else begin
          st_next.tmr[i] = st_reg.tmr[i] + 12'h001;
        end
      end else if (dem[i] && cl_s[i]) begin
        if (st_reg.tmr[i] == SETTLE_CYC) begin
          st_next.retry[i] = 1'b1;
          st_next.tmr[i] = 12'h000;
          fset[i] = 1'b1;
        end else begin
          st_next.tmr[i] = st_reg.tmr[i] + 12'h001;
        end
      end else if (cs_rise) begin
        // Restart the wait so a standing fault relatches after settle
        st_next.tmr[i] = 12'h000;
      end else if (!dem[i] && ol_s[i]) begin
        if (st_reg.tmr[i] == SETTLE_CYC) begin
          fset[i] = 1'b1;
        end else begin
          st_next.tmr[i] = st_reg.tmr[i] + 12'h001;
        end
      end else begin
        st_next.tmr[i] = 12'h000;
      end
    end

    // A new fault in the clearing cycle wins over the clear
    if (st_reg.pwr != PWR_RUN) begin
      st_next.fault = 6'h00;
    end else begin
      st_next.fault = (cs_rise ? 6'h00 : st_reg.fault) | fset;
    end

    if (st_reg.pwr == PWR_RUN && !ov_s) begin
      st_next.out = dem & ~st_reg.retry;
    end else begin
      st_next.out = 6'h00;
    end

    st_next.ser_clr = (st_next.pwr == PWR_SLEEP);
    if (cs_s) begin
      st_next.stat = {st_reg.cmd[CMD_SLEEP_BIT], 1'b0, st_reg.fault};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      st_reg <= SYS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign OUT_CH = st_reg.out;
  assign DUAL_MODE = st_reg.dual;
  assign SLEEP_ACTIVE = st_reg.ser_clr;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_hex_par_or: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (st_reg.pwr == PWR_RUN && !st_reg.dual && !ov_s && !st_reg.retry[0] &&
     st_reg.in_sync[IX_PAR0]) |=> OUT_CH[0])
    else $error("hex channel 0 not on with parallel input high");

  a_hex_upper_ser: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (!st_reg.dual && !st_reg.cmd[3]) |=> !OUT_CH[3])
    else $error("hex channel 3 on without command bit 3");

  a_dual_group_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (st_reg.pwr == PWR_RUN && st_reg.dual && !ov_s && st_reg.retry == 6'h00
     && !en_s && st_reg.cmd[0] && st_reg.cmd[4] && st_reg.cmd[5])
    |=> (OUT_CH[0] && OUT_CH[4] && OUT_CH[5]))
    else $error("dual group 0,4,5 not on with all command bits set");

  a_dual_group_b: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (st_reg.dual && !st_reg.in_sync[IX_PAR1] &&
     !(st_reg.cmd[1] && st_reg.cmd[2] && st_reg.cmd[3]))
    |=> (!OUT_CH[1] && !OUT_CH[2] && !OUT_CH[3]))
    else $error("dual group 1,2,3 on without a cause");

  a_mode_filter: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    $rose(st_reg.dual) |-> $past(st_reg.mode_cnt) == MODE_CYC)
    else $error("dual mode entered before the filter time");

  a_retry_off: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    $rose(st_reg.retry[0]) |=> !OUT_CH[0] [*8])
    else $error("channel 0 not held off during retry");

  a_fault_clear: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (cs_rise && st_reg.pwr == PWR_RUN) |=> (st_reg.fault & ~$past(fset)) == 0)
    else $error("faults survived chip select rising");

  a_cmd_load: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (cs_rise && st_reg.pwr == PWR_RUN) |=> st_reg.cmd == $past(rx_reg))
    else $error("command word not taken at chip select rising");

  a_dead_off: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (st_reg.pwr == PWR_DEAD) |=> OUT_CH == 6'h00)
    else $error("output on during dead time");

  a_ov_off: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    ov_s |=> OUT_CH == 6'h00)
    else $error("output on during overvoltage");

  a_sleep_enter: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (st_reg.pwr == PWR_RUN && en_s && st_reg.cmd[CMD_SLEEP_BIT])
    |=> ##1 (SLEEP_ACTIVE && st_reg.fault == 6'h00 && OUT_CH == 6'h00))
    else $error("sleep not entered with enable high and sleep bit");

endmodule

// ### inc/lssc_pkg.sv
// Constants and types shared by the low-side switch control logic
package lssc_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_POR_NS = 40000;
  localparam int T_MODE_NS = 10000;
  localparam int T_SETTLE_NS = 20000;
  localparam int T_RETRY_NS = 30000;
  localparam logic [11:0] POR_CYC =
    12'((T_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] MODE_CYC =
    12'((T_MODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] SETTLE_CYC =
    12'((T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] RETRY_CYC =
    12'((T_RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ------------------------------------------------------------
  // Command and status word
  // ------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int CMD_SLEEP_BIT = 7;
  localparam logic [7:0] CMD_RST = 8'h80;
  localparam logic [7:0] STAT_RST = 8'h80;
  localparam logic [3:0] SO_LAST_CNT = 4'h8;

  // ------------------------------------------------------------
  // Positions in the synchronised input vector
  // ------------------------------------------------------------
  localparam int IX_OL = 0;
  localparam int IX_CL = 6;
  localparam int IX_CS = 12;
  localparam int IX_EN = 13;
  localparam int IX_PAR0 = 14;
  localparam int IX_PAR1 = 15;
  localparam int IX_PAR2 = 16;
  localparam int IX_MID = 17;
  localparam int IX_OV = 18;
  localparam int SYNC_W = 19;
  localparam logic [18:0] SYNC_RST = 19'h01000;

  typedef enum logic [1:0] {
    PWR_DEAD,
    PWR_RUN,
    PWR_SLEEP
  } lssc_pwr_type;

endpackage

// ### verif/lssc_spi_ctrl.sv
// Behavioural serial controller facing the switch control logic
`timescale 1ns/1ps
module lssc_spi_ctrl (
  output logic SCLK, // Serial clock, runs only within frames
  output logic CS_B, // Chip select, active low
  output logic SI, // Serial data to the device
  input wire logic SO // Resolved serial data from the device
);
  initial begin
    SCLK = 1'b0;
    CS_B = 1'b1;
    SI = 1'b0;
  end

  // ------------------------------------------------------------
  // Frame of 8 or 16 bits, MSB first, 125 ns link clock
  // ------------------------------------------------------------
  task automatic xfer(input logic [15:0] tx, input logic long,
                      output logic [15:0] rx);
    int n;
    n = long ? 16 : 8;
    rx = 16'h0000;
    #3 CS_B = 1'b0;
    // Lead time before the first rising edge
    #150;
    for (int i = n - 1; i >= 0; i--) begin
      SI = tx[i];
      // Take SO just before the edge; it last moved on a falling edge
      #62.5 rx = {rx[14:0], SO};
      SCLK = 1'b1;
      #62.5 SCLK = 1'b0;
    end
    #20 CS_B = 1'b1;
    // Deselected data line must not look like a held bit
    SI = ~SI;
  endtask
endmodule

// ### verif/test_lssc_top.sv
// Self-checking bench for the low-side switch control logic
`timescale 1ns/1ps
module test_lssc_top;
  import lssc_pkg::*;
  logic CLK_SYS = 1'b0;
  logic RST_B = 1'b0;
  logic SCLK, CS_B, SI, SO_O, SO_OE, so_wire;
  logic so_float = 1'b0;
  logic EN_B = 1'b0;
  logic PAR_IN0 = 1'b0;
  logic PAR_IN1 = 1'b0;
  logic PAR_IN2_MODE_SELECT = 1'b0;
  logic MODE_MID = 1'b0;
  logic OVERVOLTAGE = 1'b0;
  logic [5:0] CUR_LIMIT = 6'h00;
  logic [5:0] OPEN_LOAD = 6'h00;
  logic [5:0] OUT_CH;
  logic DUAL_MODE, SLEEP_ACTIVE;
  logic [15:0] rx;
  logic [7:0] prev;
  logic [32:0] note;
  logic [32:0] exp_q[$];
  logic [31:0] seed = 32'h0000AB2B;
  logic [7:0] dual_cmd [4] = '{8'h31, 8'h0E, 8'h3F, 8'h2D};
  int fail_count = 0;
  int checks = 0;
  event obs_ev;

  always #5 CLK_SYS = ~CLK_SYS;
  // Released line shows a changing pattern, not the last bit
  always @(posedge CLK_SYS) so_float <= ~so_float;
  assign so_wire = SO_OE ? SO_O : so_float;

  lssc_top u_dut (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .SCLK(SCLK),
    .CS_B(CS_B), .SI(SI), .SO_O(SO_O), .SO_OE(SO_OE), .EN_B(EN_B),
    .PAR_IN0(PAR_IN0), .PAR_IN1(PAR_IN1),
    .PAR_IN2_MODE_SELECT(PAR_IN2_MODE_SELECT), .MODE_MID(MODE_MID),
    .OVERVOLTAGE(OVERVOLTAGE), .CUR_LIMIT(CUR_LIMIT),
    .OPEN_LOAD(OPEN_LOAD), .OUT_CH(OUT_CH), .DUAL_MODE(DUAL_MODE),
    .SLEEP_ACTIVE(SLEEP_ACTIVE));
  lssc_spi_ctrl u_spi (.SCLK(SCLK), .CS_B(CS_B), .SI(SI), .SO(so_wire));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [5:0] dualo(input logic [7:0] c,
                                       input logic [1:0] p);
    logic a, b;
    a = p[0] | (c[0] & c[4] & c[5]);
    b = p[1] | (&c[3:1]);
    return {a, a, b, b, b, a};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic test_done;
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Ends on a rising edge so following drives land on it
  task automatic see(input int n, input logic [15:0] mask, want);
    repeat (n) @(posedge CLK_SYS);
    #1;
    exp_q.push_back({1'b0, mask, want});
    ->obs_ev;
    @(posedge CLK_SYS);
  endtask

  task automatic frame(input logic [15:0] tx, input logic long,
                       input logic [15:0] want);
    u_spi.xfer(tx, long, rx);
    exp_q.push_back({1'b1, 16'hFFFF, want});
    ->obs_ev;
    repeat (10) @(posedge CLK_SYS);
  endtask

  task automatic set_par(input logic [2:0] p);
    PAR_IN0 <= p[0];
    PAR_IN1 <= p[1];
    PAR_IN2_MODE_SELECT <= p[2];
  endtask

  always @(obs_ev) begin
    note = exp_q.pop_front();
    check((note[32] ? rx : {7'h00, SO_OE, SLEEP_ACTIVE, DUAL_MODE, OUT_CH})
      & note[31:16], note[15:0]);
  end

  initial begin
    repeat (100000) @(posedge CLK_SYS);
    fail_count++;
    test_done;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    set_par(3'b001);
    see(2000, 16'h003F, 16'h0000);
    see(2100, 16'h00FF, 16'h0001);
    set_par(3'b000);
    frame(16'h0000, 1'b0, 16'h0080);
    prev = 8'h00;
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      set_par(seed[10:8]);
      frame({8'h00, seed[7:0]}, 1'b0, {8'h00, prev[7], 7'h00});
      see(5, 16'h003F, {10'h000, seed[5:3], seed[2:0] | seed[10:8]});
      prev = seed[7:0];
    end
    set_par(3'b000);
    frame(16'h5A07, 1'b1, {prev[7], 7'h00, 8'h5A});
    see(5, 16'h013F, 16'h0007);
    EN_B <= 1'b1;
    see(6, 16'h00FF, 16'h0000);
    set_par(3'b100);
    see(6, 16'h00FF, 16'h0004);
    set_par(3'b000);
    EN_B <= 1'b0;
    see(6, 16'h003F, 16'h0007);
    OVERVOLTAGE <= 1'b1;
    see(6, 16'h003F, 16'h0000);
    OVERVOLTAGE <= 1'b0;
    see(6, 16'h003F, 16'h0007);
    MODE_MID <= 1'b1;
    see(900, 16'h0040, 16'h0000);
    see(200, 16'h0040, 16'h0040);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      set_par({1'b0, seed[1:0]});
      frame({8'h00, dual_cmd[i]}, 1'b0, 16'h0000);
      see(5, 16'h007F, {10'h001, dualo(dual_cmd[i], seed[1:0])});
    end
    MODE_MID <= 1'b0;
    set_par(3'b000);
    see(6, 16'h0040, 16'h0000);
    frame(16'h0001, 1'b0, 16'h0000);
    OPEN_LOAD <= 6'h04;
    CUR_LIMIT <= 6'h01;
    see(2100, 16'h003F, 16'h0000);
    CUR_LIMIT <= 6'h00;
    see(3100, 16'h003F, 16'h0001);
    frame(16'h0001, 1'b0, 16'h0005);
    frame(16'h0001, 1'b0, 16'h0000);
    see(2100, 16'h003F, 16'h0001);
    frame(16'h0080, 1'b0, 16'h0004);
    OPEN_LOAD <= 6'h00;
    EN_B <= 1'b1;
    set_par(3'b011);
    see(8, 16'h00BF, 16'h0080);
    EN_B <= 1'b0;
    see(2000, 16'h003F, 16'h0000);
    see(2100, 16'h00FF, 16'h0003);
    frame(16'h0000, 1'b0, 16'h0080);
    test_done;
  end
endmodule
